// [src/strobe_pkg.sv]
package strobe_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] SETTING_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS  = 8'h08;
  localparam logic [7:0] TAP_OFS     = 8'h10;
  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_UPD_USER_BIT  = 0;
  localparam int CTRL_HALF_RATE_BIT = 1;
  localparam int CTRL_TERM_LVL_BIT  = 2;
  localparam int CTRL_POST_EN_BIT   = 3;
  localparam int CTRL_CHAIN_LSB     = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
  // ----------------------------------------------------------------
  // setting and tap fields
  // ----------------------------------------------------------------
  localparam int DELAY_W    = 6;
  localparam int OFFSET_W   = 7;
  localparam int OFFSET_LSB = 8;
  localparam int TAP_W      = 3;
  localparam int TAP_WR_LSB = 0;
  localparam int TAP_RS_LSB = 4;
  localparam int TAP_PA_LSB = 8;
  localparam logic [TAP_W-1:0] DQ_LAG_TAPS = 3'h2;
  localparam logic [TAP_W-1:0] HALF_PHASE  = 3'h4;
  localparam int NUM_PHASES = 8;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int UPD_PERIOD_NS   = 80;
  localparam int UPD_PERIOD_CYC  = UPD_PERIOD_NS / CLK_PERIOD_NS;
  localparam int UPD_CNT_W       = 8;
endpackage : strobe_pkg

// [src/level_tap.sv]
`timescale 1ns/100ps
`default_nettype none
module level_tap
  import strobe_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [TAP_W-1:0] phase,
  input  wire logic [TAP_W-1:0] wr_tap,
  input  wire logic [TAP_W-1:0] rs_tap,
  input  wire logic [TAP_W-1:0] pa_tap,
  input  wire logic             chain_en,
  input  wire logic             chain_in,
  output logic                  dqs_clk_q,
  output logic                  dq_clk_q,
  output logic                  rs_clk_q,
  output logic                  pa_clk_q,
  output logic                  hr_clk_q
);
  // ----------------------------------------------------------------
  // tap selection
  // ----------------------------------------------------------------
  // a tap is high for the first half of its eight-phase period
  function automatic logic tap_level(input logic [TAP_W-1:0] p,
                                     input logic [TAP_W-1:0] t);
    logic [TAP_W-1:0] d;
    d = p - t;
    return d < HALF_PHASE;
  endfunction

  logic own_hr_q;
  logic rs_prev_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dqs_clk_q <= 1'b0;
      dq_clk_q  <= 1'b0;
      rs_clk_q  <= 1'b0;
      pa_clk_q  <= 1'b0;
      rs_prev_q <= 1'b0;
    end
    else
    begin
      dqs_clk_q <= tap_level(phase, wr_tap);
      dq_clk_q  <= tap_level(phase, wr_tap + DQ_LAG_TAPS);
      rs_clk_q  <= tap_level(phase, rs_tap);
      pa_clk_q  <= tap_level(phase, pa_tap);
      rs_prev_q <= rs_clk_q;
    end
  end

  // ----------------------------------------------------------------
  // half-rate divider, own or chained from the neighbour
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      own_hr_q <= 1'b0;
    else if (rs_clk_q && !rs_prev_q)
      own_hr_q <= ~own_hr_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hr_clk_q <= 1'b0;
    else
      hr_clk_q <= chain_en ? chain_in : own_hr_q;
  end
endmodule // level_tap
`default_nettype wire

// [src/strobe_path.sv]
`timescale 1ns/100ps
`default_nettype none
module strobe_path #(
  parameter int GROUPS = 4
) (
  input  wire logic                        CLK,
  input  wire logic                        RSTN,
  input  wire logic                        HSEL,
  input  wire logic [7:0]                  HADDR,
  input  wire logic [1:0]                  HTRANS,
  input  wire logic                        HWRITE,
  input  wire logic [2:0]                  HSIZE,
  input  wire logic [31:0]                 HWDATA,
  input  wire logic                        HREADY,
  output logic [31:0]                      HRDATA,
  output logic                             HREADYOUT,
  output logic                             HRESP,
  input  wire logic                        USER_CLK,
  input  wire logic                        DQS_IN,
  input  wire logic                        CHAIN_IN,
  input  wire logic                        GATE_REQ,
  input  wire logic                        RD_ACTIVE,
  input  wire logic                        WR_ACTIVE,
  output logic                             UPDATE_EN,
  output logic [strobe_pkg::DELAY_W-1:0]   DELAY_SETTING,
  output logic [strobe_pkg::OFFSET_W-1:0]  PHASE_OFFSET,
  output logic [strobe_pkg::DELAY_W-1:0]   LVL_SETTING,
  output logic                             STROBE_GATE,
  output logic                             DQS_GATED,
  output logic                             TERM_EN,
  output logic [GROUPS-1:0]                WL_DQS_CLK,
  output logic [GROUPS-1:0]                WL_DQ_CLK,
  output logic [GROUPS-1:0]                RL_RESYNC_CLK,
  output logic [GROUPS-1:0]                RL_POST_CLK,
  output logic [GROUPS-1:0]                HR_RESYNC_CLK,
  output logic                             CHAIN_OUT
);
  import strobe_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0]           ctrl_q;
  logic [DELAY_W-1:0]    req_delay_q;
  logic [OFFSET_W-1:0]   req_offset_q;
  logic [3*TAP_W+2:0]    tap_q [GROUPS];
  logic                  wr_pend_q;
  logic [7:0]            wr_addr_q;
  logic [31:0]           rd_data_d;
  logic                  addr_ok;
  logic [UPD_CNT_W-1:0]  upd_cnt_q;
  logic                  usr_s1_q;
  logic                  usr_s2_q;
  logic                  usr_s3_q;
  logic                  upd_pulse;
  logic                  dqs_s1_q;
  logic                  dqs_s2_q;
  logic                  chn_s1_q;
  logic                  chn_s2_q;
  logic                  hr_tick_q;
  logic                  stage1_q;
  logic                  post_q;
  logic                  gate_on;
  logic [TAP_W-1:0]      phase_q;
  logic                  term_tick;
  logic                  term_prev_q;
  logic [GROUPS:0]       chain;

  // ----------------------------------------------------------------
  // bus slave, zero wait states
  // ----------------------------------------------------------------
  // read data is produced at the address phase so it stands for the
  // whole data phase without stretching the transfer
  assign addr_ok = HSEL && HREADY && HTRANS[1];

  always_comb
  begin
    rd_data_d = 32'h0000_0000;
    if (HADDR == CTRL_OFS)
      rd_data_d = ctrl_q;
    else if (HADDR == SETTING_OFS)
    begin
      rd_data_d[DELAY_W-1:0] = req_delay_q;
      rd_data_d[OFFSET_LSB +: OFFSET_W] = req_offset_q;
    end
    else if (HADDR == STATUS_OFS)
    begin
      rd_data_d[DELAY_W-1:0] = DELAY_SETTING;
      rd_data_d[OFFSET_LSB +: OFFSET_W] = PHASE_OFFSET;
      rd_data_d[16] = TERM_EN;
      rd_data_d[17] = STROBE_GATE;
      rd_data_d[18] = UPDATE_EN;
      rd_data_d[22:20] = phase_q;
    end
    else
      for (int g = 0; g < GROUPS; g++)
        if (HADDR == TAP_OFS + 8'(4 * g))
          rd_data_d[3*TAP_W+2:0] = tap_q[g];
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
    else
    begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      if (addr_ok && !HWRITE)
        HRDATA <= rd_data_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= addr_ok && HWRITE;
      if (addr_ok)
        wr_addr_q <= HADDR;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      ctrl_q       <= CTRL_RESET;
      req_delay_q  <= '0;
      req_offset_q <= '0;
    end
    else if (wr_pend_q)
    begin
      if (wr_addr_q == CTRL_OFS)
        ctrl_q <= HWDATA & 32'(((1 << (CTRL_CHAIN_LSB + GROUPS)) - 1));
      if (wr_addr_q == SETTING_OFS)
      begin
        req_delay_q  <= HWDATA[DELAY_W-1:0];
        req_offset_q <= HWDATA[OFFSET_LSB +: OFFSET_W];
      end
    end
  end

  // tap words: bits wr, rs, pa; the controller sweeps and then picks
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      for (int g = 0; g < GROUPS; g++)
        tap_q[g] <= '0;
    end
    else if (wr_pend_q)
    begin
      for (int g = 0; g < GROUPS; g++)
        if (wr_addr_q == TAP_OFS + 8'(4 * g))
          tap_q[g] <= HWDATA[3*TAP_W+2:0];
    end
  end

  // ----------------------------------------------------------------
  // update enable
  // ----------------------------------------------------------------
  // the user clock comes from another domain: two stages, then edge
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      usr_s1_q <= 1'b0;
      usr_s2_q <= 1'b0;
      usr_s3_q <= 1'b0;
    end
    else
    begin
      usr_s1_q <= USER_CLK;
      usr_s2_q <= usr_s1_q;
      usr_s3_q <= usr_s2_q;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      upd_cnt_q <= '0;
    else if (upd_cnt_q == UPD_CNT_W'(UPD_PERIOD_CYC - 1))
      upd_cnt_q <= '0;
    else
      upd_cnt_q <= upd_cnt_q + 1'b1;
  end

  assign upd_pulse = ctrl_q[CTRL_UPD_USER_BIT]
                     ? (usr_s2_q && !usr_s3_q)
                     : (upd_cnt_q == UPD_CNT_W'(UPD_PERIOD_CYC - 1));

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      UPDATE_EN <= 1'b0;
    else
      UPDATE_EN <= upd_pulse;
  end

  // all chains see the new word at once; otherwise the old one holds
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      DELAY_SETTING <= '0;
      PHASE_OFFSET  <= '0;
      LVL_SETTING   <= '0;
    end
    else if (upd_pulse)
    begin
      DELAY_SETTING <= req_delay_q;
      PHASE_OFFSET  <= req_offset_q;
      LVL_SETTING   <= req_delay_q;
    end
  end

  // ----------------------------------------------------------------
  // postamble gating
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      dqs_s1_q <= 1'b0;
      dqs_s2_q <= 1'b0;
    end
    else
    begin
      dqs_s1_q <= DQS_IN;
      dqs_s2_q <= dqs_s1_q;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      hr_tick_q <= 1'b0;
    else
      hr_tick_q <= ~hr_tick_q;
  end

  // half-rate stage samples only on alternate edges
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      stage1_q <= 1'b0;
    else if (!ctrl_q[CTRL_HALF_RATE_BIT] || hr_tick_q)
      stage1_q <= GATE_REQ;
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      post_q <= 1'b0;
    else
      post_q <= stage1_q;
  end

  // a stale high in one stage cannot reopen the gate by itself
  assign gate_on = stage1_q && post_q;

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      STROBE_GATE <= 1'b0;
      DQS_GATED   <= 1'b0;
    end
    else
    begin
      STROBE_GATE <= gate_on;
      if (ctrl_q[CTRL_POST_EN_BIT])
        DQS_GATED <= dqs_s2_q && gate_on;
      else
        DQS_GATED <= dqs_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // leveling phases, one set per sub-bank
  // ----------------------------------------------------------------
  // only one interface may own these phases at a time
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      phase_q <= '0;
    else
      phase_q <= phase_q + 1'b1;
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      chn_s1_q <= 1'b0;
      chn_s2_q <= 1'b0;
    end
    else
    begin
      chn_s1_q <= CHAIN_IN;
      chn_s2_q <= chn_s1_q;
    end
  end

  assign chain[0] = chn_s2_q;

  for (genvar g = 0; g < GROUPS; g++)
  begin : grp
    level_tap u_tap (
      .clk       (CLK),
      .rst_n     (RSTN),
      .phase     (phase_q),
      .wr_tap    (tap_q[g][TAP_WR_LSB +: TAP_W]),
      .rs_tap    (tap_q[g][TAP_RS_LSB +: TAP_W]),
      .pa_tap    (tap_q[g][TAP_PA_LSB +: TAP_W]),
      .chain_en  (ctrl_q[CTRL_CHAIN_LSB + g]),
      .chain_in  (chain[g]),
      .dqs_clk_q (WL_DQS_CLK[g]),
      .dq_clk_q  (WL_DQ_CLK[g]),
      .rs_clk_q  (RL_RESYNC_CLK[g]),
      .pa_clk_q  (RL_POST_CLK[g]),
      .hr_clk_q  (HR_RESYNC_CLK[g])
    );
    assign chain[g+1] = HR_RESYNC_CLK[g];
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      CHAIN_OUT <= 1'b0;
    else
      CHAIN_OUT <= chain[GROUPS];
  end

  // ----------------------------------------------------------------
  // dynamic termination
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      term_prev_q <= 1'b0;
    else
      term_prev_q <= WL_DQS_CLK[0];
  end

  // leveled clock costs up to a phase period of latency
  assign term_tick = ctrl_q[CTRL_TERM_LVL_BIT]
                     ? (WL_DQS_CLK[0] && !term_prev_q) : 1'b1;

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      TERM_EN <= 1'b0;
    else if (term_tick)
    begin
      if (WR_ACTIVE)
        TERM_EN <= 1'b0;
      else if (RD_ACTIVE)
        TERM_EN <= 1'b1;
    end
  end
endmodule // strobe_path
`default_nettype wire

// [verif/strobe_path_properties.sv]
`timescale 1ns/100ps
`default_nettype none
// ------
// port checks
// ------
module strobe_path_properties #(
  parameter int GROUPS = 4
) (
  input wire logic                          CLK,
  input wire logic                          RSTN,
  input wire logic                          GATE_REQ,
  input wire logic                          RD_ACTIVE,
  input wire logic                          WR_ACTIVE,
  input wire logic                          UPDATE_EN,
  input wire logic [strobe_pkg::DELAY_W-1:0] DELAY_SETTING,
  input wire logic                          STROBE_GATE,
  input wire logic                          DQS_GATED,
  input wire logic                          TERM_EN,
  input wire logic [GROUPS-1:0]             WL_DQS_CLK,
  input wire logic [GROUPS-1:0]             WL_DQ_CLK,
  input wire logic                          HREADYOUT,
  input wire logic                          HRESP
);
  import strobe_pkg::*;
  logic [3:0] run_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // taps are judged only once the phase counter has run past reset
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      run_q <= 4'h0;
    else if (run_q != 4'hf)
      run_q <= run_q + 4'h1;
  end
  upd_hold_a: assert property (!UPDATE_EN |-> $stable(DELAY_SETTING))
    else $error("setting moved without update");
  upd_gap_a: assert property (UPDATE_EN |=> !UPDATE_EN [*7])
    else $error("update pulses too close");
  gate_early_a: assert property ($rose(GATE_REQ) && !STROBE_GATE
    |=> !STROBE_GATE [*2]) else $error("gate opened early");
  gate_rise_a: assert property ($rose(GATE_REQ) && !STROBE_GATE
    ##1 GATE_REQ [*2] |=> STROBE_GATE) else $error("gate late");
  gate_fall_a: assert property ($fell(GATE_REQ) && STROBE_GATE
    |=> STROBE_GATE ##1 !STROBE_GATE) else $error("gate close wrong");
  gated_off_a: assert property (!STROBE_GATE && !$past(STROBE_GATE)
    |-> !DQS_GATED) else $error("strobe passed closed gate");
  term_wr_a: assert property (WR_ACTIVE |=> !TERM_EN)
    else $error("termination on in write");
  term_rd_a: assert property (RD_ACTIVE && !WR_ACTIVE |=> TERM_EN)
    else $error("termination off in read");
  dq_lag_a: assert property (run_q == 4'hf
    |-> WL_DQ_CLK[0] == $past(WL_DQS_CLK[0], 2)) else $error("dq lag");
  tap_period_a: assert property (run_q == 4'hf
    |-> WL_DQS_CLK[0] != $past(WL_DQS_CLK[0], 4)) else $error("tap period");
  bus_ok_a: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
endmodule // strobe_path_properties
bind strobe_path strobe_path_properties #(.GROUPS(GROUPS)) i_props (
  .CLK, .RSTN, .GATE_REQ, .RD_ACTIVE, .WR_ACTIVE, .UPDATE_EN,
  .DELAY_SETTING, .STROBE_GATE, .DQS_GATED, .TERM_EN, .WL_DQS_CLK,
  .WL_DQ_CLK, .HREADYOUT, .HRESP
);
`default_nettype wire

// [verif/sdram_strobe_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ------
// memory read strobe
// ------
module sdram_strobe_model #(
  parameter int BURST = 8
) (
  input  wire logic clk,
  input  wire logic rd_go,
  output logic      dqs
);
  logic [4:0] cnt_q;
  initial
  begin
    cnt_q = 5'h00;
    dqs = 1'b0;
  end
  // a released line floats: a pattern flipping every cycle stands in
  always @(posedge clk)
  begin
    if (rd_go && cnt_q == 5'h00)
      cnt_q <= 5'(BURST + 2);
    else if (cnt_q != 5'h00)
      cnt_q <= cnt_q - 5'h01;
    if (cnt_q == 5'(BURST + 2) || cnt_q == 5'h01)
      dqs <= 1'b0;
    else
      dqs <= ~dqs;
  end
endmodule // sdram_strobe_model
`default_nettype wire

// [verif/strobe_path_test.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHECK(n, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("CHECK FAILED %s exp %h got %h", n, e, g); \
    end \
  end
module strobe_path_test;
  import strobe_pkg::*;
  logic        CLK, RSTN, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, rd_go;
  logic        USER_CLK, DQS_IN, CHAIN_IN, GATE_REQ, RD_ACTIVE, CHAIN_OUT;
  logic        WR_ACTIVE, UPDATE_EN, STROBE_GATE, DQS_GATED, TERM_EN;
  logic [7:0]  HADDR;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [31:0] HWDATA, HRDATA, d;
  logic [5:0]  DELAY_SETTING, LVL_SETTING;
  logic [6:0]  PHASE_OFFSET;
  logic [3:0]  WL_DQS_CLK, WL_DQ_CLK, RL_RESYNC_CLK, RL_POST_CLK;
  logic [3:0]  HR_RESYNC_CLK;
  int          fails, total_checks;
  assign HREADY = HREADYOUT;
  always #5 CLK = ~CLK;
  strobe_path #(.GROUPS(4)) i_strobe_path (
    .CLK, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY, .HRDATA, .HREADYOUT, .HRESP, .USER_CLK, .DQS_IN,
    .CHAIN_IN, .GATE_REQ, .RD_ACTIVE, .WR_ACTIVE, .UPDATE_EN,
    .DELAY_SETTING, .PHASE_OFFSET, .LVL_SETTING, .STROBE_GATE,
    .DQS_GATED, .TERM_EN, .WL_DQS_CLK, .WL_DQ_CLK, .RL_RESYNC_CLK,
    .RL_POST_CLK, .HR_RESYNC_CLK, .CHAIN_OUT
  );
  sdram_strobe_model i_sdram_strobe_model (.clk(CLK), .rd_go, .dqs(DQS_IN));
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ------
  // bus and waits
  // ------
  task automatic bus_wait();
    int n;
    n = 0;
    @(posedge CLK);
    while (HREADY !== 1'b1)
    begin
      n++;
      if (n > 40)
      begin
        fails++;
        test_done();
      end
      @(posedge CLK);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v);
    HSEL <= 1'b1;
    HADDR <= a;
    HTRANS <= 2'b10;
    HWRITE <= w;
    bus_wait();
    HTRANS <= 2'b00;
    HWDATA <= v;
    bus_wait();
    d = HRDATA;
  endtask
  task automatic wait_delay(input logic [5:0] e, input int lim, output int n);
    n = 0;
    while (DELAY_SETTING !== e && n < lim)
    begin
      @(posedge CLK);
      #1;
      n++;
    end
  endtask
  // ------
  // scenarios
  // ------
  task automatic regs_check();
    bus(CTRL_OFS, 1'b0, 32'h0);
    `CHECK("ctrl", CTRL_RESET, d)
    bus(STATUS_OFS, 1'b0, 32'h0);
    `CHECK("status", 32'h0, d & 32'h0003_ffff)
    bus(8'h0c, 1'b1, 32'hffff_ffff);
    bus(8'h0c, 1'b0, 32'h0);
    `CHECK("unmapped", 32'h0, d)
  endtask
  task automatic update_ref();
    int n;
    bus(SETTING_OFS, 1'b1, 32'h0000_552a);
    wait_delay(6'h2a, 20, n);
    `CHECK("delay", 6'h2a, DELAY_SETTING)
    `CHECK("pulse", 1'b1, UPDATE_EN)
    `CHECK("offset", 7'h55, PHASE_OFFSET)
    `CHECK("lvl", 6'h2a, LVL_SETTING)
    `CHECK("period", 1'b1, n <= UPD_PERIOD_CYC + 2)
    bus(STATUS_OFS, 1'b0, 32'h0);
    `CHECK("applied", 32'h0000_552a, d & 32'h0000_7f3f)
  endtask
  task automatic update_user();
    int n;
    bus(CTRL_OFS, 1'b1, 32'h0000_0009);
    bus(SETTING_OFS, 1'b1, 32'h0000_1105);
    wait_delay(6'h05, 30, n);
    `CHECK("held", 6'h2a, DELAY_SETTING)
    USER_CLK <= 1'b1;
    wait_delay(6'h05, 8, n);
    `CHECK("user", 6'h05, DELAY_SETTING)
    `CHECK("user lat", 1'b1, n >= 2 && n <= 6)
    USER_CLK <= 1'b0;
    // a reference pulse right after the user one would break the spacing
    repeat (8) @(posedge CLK);
    bus(CTRL_OFS, 1'b1, CTRL_RESET);
  endtask
  task automatic chain_check();
    bus(CTRL_OFS, 1'b1, 32'h0000_00f8);
    CHAIN_IN <= 1'b1;
    repeat (8) @(posedge CLK);
    #1;
    `CHECK("chain hr", 4'hf, HR_RESYNC_CLK)
    `CHECK("chain out", 1'b1, CHAIN_OUT)
    CHAIN_IN <= 1'b0;
    repeat (8) @(posedge CLK);
    #1;
    `CHECK("chain low", 1'b0, CHAIN_OUT)
    bus(CTRL_OFS, 1'b1, CTRL_RESET);
  endtask
  task automatic gate_check();
    int hits;
    hits = 0;
    GATE_REQ <= 1'b1;
    rd_go <= 1'b1;
    for (int k = 1; k <= 3; k++)
    begin
      @(posedge CLK);
      #1;
      rd_go <= 1'b0;
      `CHECK("gate rise", k == 3, STROBE_GATE)
    end
    repeat (10)
    begin
      @(posedge CLK);
      #1;
      hits += DQS_GATED;
    end
    `CHECK("gated", 1'b1, hits > 0)
    GATE_REQ <= 1'b0;
    @(posedge CLK);
    #1;
    `CHECK("gate hold", 1'b1, STROBE_GATE)
    @(posedge CLK);
    #1;
    `CHECK("gate fall", 1'b0, STROBE_GATE)
    @(posedge CLK);
    #1;
    // a lone request cycle must not reopen the gate on the glitches
    GATE_REQ <= 1'b1;
    hits = 0;
    repeat (20)
    begin
      @(posedge CLK);
      #1;
      GATE_REQ <= 1'b0;
      hits += DQS_GATED | STROBE_GATE;
    end
    `CHECK("stray", 0, hits)
  endtask
  task automatic term_check();
    logic [2:0] tv [6] = '{3'b101, 3'b110, 3'b000, 3'b101, 3'b001, 3'b010};
    foreach (tv[i])
    begin
      RD_ACTIVE <= tv[i][2];
      WR_ACTIVE <= tv[i][1];
      @(posedge CLK);
      #1;
      `CHECK("term", tv[i][0], TERM_EN)
    end
  endtask
  task automatic level_check();
    logic [3:0] h [20];
    logic       q [20];
    int         s;
    s = 0;
    bus(TAP_OFS + 8'h04, 1'b1, 32'h0000_0003);
    bus(TAP_OFS + 8'h08, 1'b1, 32'h0000_0750);
    repeat (4) @(posedge CLK);
    for (int i = 0; i < 20; i++)
    begin
      @(posedge CLK);
      #1;
      h[i] = {WL_DQS_CLK[0], WL_DQS_CLK[1], RL_RESYNC_CLK[2], RL_POST_CLK[2]};
      q[i] = WL_DQ_CLK[1];
    end
    for (int i = 8; i < 20; i++)
    begin
      `CHECK("wr tap", h[i-3][3], h[i][2])
      `CHECK("rs tap", h[i-5][3], h[i][1])
      `CHECK("pa tap", h[i-7][3], h[i][0])
      `CHECK("dq lag", h[i-5][3], q[i])
      if (i < 16)
        s += h[i][3];
    end
    `CHECK("phases", 4, s)
  endtask
  initial
  begin
    CLK = 1'b0;
    RSTN = 1'b0;
    HSEL = 1'b0;
    HADDR = 8'h00;
    HTRANS = 2'b00;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    USER_CLK = 1'b0;
    CHAIN_IN = 1'b0;
    GATE_REQ = 1'b0;
    RD_ACTIVE = 1'b0;
    WR_ACTIVE = 1'b0;
    rd_go = 1'b0;
    fails = 0;
    total_checks = 0;
    repeat (16) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    regs_check();
    update_ref();
    update_user();
    gate_check();
    term_check();
    level_check();
    chain_check();
    test_done();
  end
endmodule // strobe_path_test
`default_nettype wire
